//--- hdl/tas_alert_status.sv
`include "tas_consts.svh"

// Notes on behaviour
// - register 0x015 holds channels 0-3, resets zero
// - register 0x016 holds channels 4-7, resets zero
// - result at or below lower limit sets lower
// - result at or above upper limit sets upper
// - disabled channel never sets its alert bits
// - reading a register clears its alert bits
// - hysteresis mode clears alert once result is beyond the hysteresis band
// - summary output is OR of all alerts
// - write to alert register flags invalid write
module tas_alert_status (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    input tas_pkg::tas_conv_t conv_i,
    input tas_pkg::tas_chan_cfg_t [7:0] chan_cfg_i,
    input wire logic alert_mode_i,
    output logic [7:0] alert_status_low_channels_o,
    output logic [7:0] alert_status_mid_channels_o,
    output logic any_limit_alert_summary_o,
    output logic invalid_write_o
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] cs_s_q;
    logic [2:0] sclk_s_q;
    logic [1:0] sdi_s_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_s_q <= 3'h7;
            sclk_s_q <= 3'h0;
            sdi_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], spi_cs_n_i};
            sclk_s_q <= {sclk_s_q[1:0], spi_sclk_i};
            sdi_s_q <= {sdi_s_q[0], spi_sdi_i};
        end
    end

    logic cs_act;
    logic sclk_rise;
    logic sclk_fall;
    assign cs_act = ~cs_s_q[1];
    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];

    // ----------------------------------------
    // serial frame engine
    // ----------------------------------------
    tas_pkg::tas_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [14:0] in_sh_q, in_sh_d;
    logic [7:0] out_sh_q, out_sh_d;
    logic sdo_q, sdo_d;
    logic inv_wr_q, inv_wr_d;
    logic [15:0] alert_q, alert_d;
    logic [15:0] instr;
    logic decode;
    logic rd_clr_low;
    logic rd_clr_mid;
    logic wr_ours;

    assign instr = {in_sh_q, sdi_s_q[1]};
    assign decode = (state_q == tas_pkg::TAS_INSTR) && cs_act && sclk_rise
                    && (cnt_q == `TAS_INSTR_LAST);
    assign rd_clr_low = decode && instr[`TAS_INSTR_RW_BIT]
                        && (instr[14:0] == `TAS_ADDR_LOW_CHANNELS);
    assign rd_clr_mid = decode && instr[`TAS_INSTR_RW_BIT]
                        && (instr[14:0] == `TAS_ADDR_MID_CHANNELS);
    assign wr_ours = decode && !instr[`TAS_INSTR_RW_BIT]
                     && ((instr[14:0] == `TAS_ADDR_LOW_CHANNELS)
                     || (instr[14:0] == `TAS_ADDR_MID_CHANNELS));

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        in_sh_d = in_sh_q;
        out_sh_d = out_sh_q;
        sdo_d = sdo_q;
        inv_wr_d = wr_ours;
        case (state_q)
            tas_pkg::TAS_IDLE: begin
                cnt_d = 4'h0;
                sdo_d = 1'b0;
                if (cs_act) begin
                    state_d = tas_pkg::TAS_INSTR;
                end
            end
            tas_pkg::TAS_INSTR: begin
                if (sclk_rise) begin
                    in_sh_d = instr[14:0];
                    cnt_d = cnt_q + 4'h1;
                end
                if (decode) begin
                    state_d = tas_pkg::TAS_DATA;
                    if (rd_clr_low) begin
                        out_sh_d = alert_q[7:0];
                    end else if (rd_clr_mid) begin
                        out_sh_d = alert_q[15:8];
                    end else begin
                        out_sh_d = `TAS_READ_NONE;
                    end
                end
            end
            tas_pkg::TAS_DATA: begin
                // one data byte per frame; later bits shift out zero
                if (sclk_fall) begin
                    sdo_d = out_sh_q[7];
                    out_sh_d = {out_sh_q[6:0], 1'b0};
                end
            end
            default: begin
                state_d = tas_pkg::TAS_IDLE;
            end
        endcase
        if (!cs_act) begin
            state_d = tas_pkg::TAS_IDLE;
            sdo_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= tas_pkg::TAS_IDLE;
            cnt_q <= 4'h0;
            in_sh_q <= 15'h0000;
            out_sh_q <= 8'h00;
            sdo_q <= 1'b0;
            inv_wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            in_sh_q <= in_sh_d;
            out_sh_q <= out_sh_d;
            sdo_q <= sdo_d;
            inv_wr_q <= inv_wr_d;
        end
    end

    // ----------------------------------------
    // threshold compare and alert flags
    // ----------------------------------------
    logic [15:0] set_vec;
    logic [15:0] hclr_vec;
    logic [15:0] clr_vec;
    logic summary_q, summary_d;

    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_chan
            logic hit;
            assign hit = conv_i.valid && (conv_i.chan == 3'(n));
            assign set_vec[2*n] = hit && chan_cfg_i[n].enable
                                  && (conv_i.result >= chan_cfg_i[n].upper);
            assign set_vec[2*n+1] = hit && chan_cfg_i[n].enable
                                    && (conv_i.result <= chan_cfg_i[n].lower);
            // sums kept 17 bits wide so limits near full scale cannot wrap
            assign hclr_vec[2*n] = hit && alert_mode_i
                && (({1'b0, conv_i.result} + {1'b0, chan_cfg_i[n].hyst})
                < {1'b0, chan_cfg_i[n].upper});
            assign hclr_vec[2*n+1] = hit && alert_mode_i
                && ({1'b0, conv_i.result}
                > ({1'b0, chan_cfg_i[n].lower} + {1'b0, chan_cfg_i[n].hyst}));
        end
    endgenerate

    assign clr_vec = hclr_vec | {{8{rd_clr_mid}}, {8{rd_clr_low}}};

    always_comb begin
        alert_d = (alert_q & ~clr_vec) | set_vec;
        summary_d = |alert_d;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alert_q <= {`TAS_RST_ALERT_STATUS, `TAS_RST_ALERT_STATUS};
            summary_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
            summary_q <= summary_d;
        end
    end

    assign alert_status_low_channels_o = alert_q[7:0];
    assign alert_status_mid_channels_o = alert_q[15:8];
    assign any_limit_alert_summary_o = summary_q;
    assign invalid_write_o = inv_wr_q;
    assign spi_sdo_o = sdo_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    assign hi_idx = {conv_i.chan, `TAS_UPPER_BIT};
    assign lo_idx = {conv_i.chan, `TAS_LOWER_BIT};

    sequence s_write_alert_reg;
        wr_ours;
    endsequence

    sequence s_flag_pulse;
        invalid_write_o ##1 !invalid_write_o;
    endsequence

    a_upper_set: assert property (
        conv_i.valid && chan_cfg_i[conv_i.chan].enable
        && (conv_i.result >= chan_cfg_i[conv_i.chan].upper)
        |=> alert_q[$past(hi_idx)])
        else $error("upper alert not set");
    a_lower_set: assert property (
        conv_i.valid && chan_cfg_i[conv_i.chan].enable
        && (conv_i.result <= chan_cfg_i[conv_i.chan].lower)
        |=> alert_q[$past(lo_idx)])
        else $error("lower alert not set");
    a_disabled_no_set: assert property (
        conv_i.valid && !chan_cfg_i[conv_i.chan].enable
        && !alert_q[hi_idx] && !alert_q[lo_idx]
        |=> !alert_q[$past(hi_idx)] && !alert_q[$past(lo_idx)])
        else $error("disabled channel raised alert");
    a_read_clears_low: assert property (
        rd_clr_low && (set_vec[7:0] == 8'h00)
        |=> alert_status_low_channels_o == 8'h00)
        else $error("low register read did not clear");
    a_read_clears_mid: assert property (
        rd_clr_mid && (set_vec[15:8] == 8'h00)
        |=> alert_status_mid_channels_o == 8'h00)
        else $error("mid register read did not clear");
    a_fall_cause: assert property (
        $fell(alert_q[0]) |-> $past(rd_clr_low
        || (alert_mode_i && conv_i.valid && (conv_i.chan == 3'h0))))
        else $error("alert cleared without cause");
    a_summary_or: assert property (
        any_limit_alert_summary_o == (|{alert_status_mid_channels_o,
        alert_status_low_channels_o}))
        else $error("summary differs from alert OR");
    a_invalid_write: assert property (
        s_write_alert_reg |=> s_flag_pulse)
        else $error("invalid write flag not pulsed");
    a_set_beats_clear: assert property (
        rd_clr_low && set_vec[0] |=> alert_q[0] ##0 $past(out_sh_d[0]) == $past(alert_q[0]))
        else $error("alert lost on read clear");

endmodule : tas_alert_status

//--- hdl/tas_consts.svh
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define TAS_ADDR_LOW_CHANNELS 15'h0015
`define TAS_ADDR_MID_CHANNELS 15'h0016
`define TAS_RST_ALERT_STATUS 8'h00
`define TAS_READ_NONE 8'h00

// ----------------------------------------
// field layout
// ----------------------------------------
`define TAS_UPPER_BIT 1'h0
`define TAS_LOWER_BIT 1'h1
`define TAS_INSTR_RW_BIT 15

// ----------------------------------------
// serial frame timing
// ----------------------------------------
`define TAS_INSTR_LAST 4'hF

`endif

//--- hdl/tas_pkg.sv
package tas_pkg;

    typedef struct packed {
        logic enable;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] hyst;
    } tas_chan_cfg_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [15:0] result;
    } tas_conv_t;

    typedef enum logic [2:0] {
        TAS_IDLE = 3'b001,
        TAS_INSTR = 3'b010,
        TAS_DATA = 3'b100
    } tas_state_t;

endpackage : tas_pkg

//--- verif/tas_alert_status_bench.sv
`include "tas_consts.svh"
module tas_alert_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cs_n, sclk, sdi, sdo, mode, summary, inval;
    tas_pkg::tas_conv_t conv = '0;
    tas_pkg::tas_chan_cfg_t [7:0] cfg;
    logic [7:0] low, mid, rd;
    logic [15:0] exp_q = 16'h0000;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int inval_seen = 0;

    tas_alert_status DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .spi_cs_n_i(cs_n),
        .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .conv_i(conv),
        .chan_cfg_i(cfg), .alert_mode_i(mode), .alert_status_low_channels_o(low),
        .alert_status_mid_channels_o(mid), .any_limit_alert_summary_o(summary),
        .invalid_write_o(inval));
    tas_host_model host (.clk_i(clk_sys_i), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk),
        .sdi_o(sdi));

    always #2 clk_sys_i = ~clk_sys_i;

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_sys_i) begin
        cycles++;
        if (inval === 1'b1) inval_seen++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic compare;
        // look away from the edge that launches the outputs
        @(negedge clk_sys_i);
        check({mid, low} === exp_q, "alert bits");
        check(summary === |exp_q, "summary");
    endtask : compare

    // set wins over hysteresis clear
    function automatic logic [15:0] predict(logic [15:0] cur, logic [2:0] ch,
        logic [15:0] res, tas_pkg::tas_chan_cfg_t g, logic m);
        logic [15:0] n;
        n = cur;
        if (m && ({1'b0, res} + g.hyst < {1'b0, g.upper})) n[2 * ch] = 1'b0;
        if (m && ({1'b0, res} > {1'b0, g.lower} + g.hyst)) n[2 * ch + 1] = 1'b0;
        if (g.enable && res >= g.upper) n[2 * ch] = 1'b1;
        if (g.enable && res <= g.lower) n[2 * ch + 1] = 1'b1;
        return n;
    endfunction : predict

    task automatic convert(input logic [2:0] ch, input logic [15:0] res);
        @(posedge clk_sys_i) conv <= '{valid: 1'b1, chan: ch, result: res};
        exp_q = predict(exp_q, ch, res, cfg[ch], mode);
        @(posedge clk_sys_i) conv.valid <= 1'b0;
        compare();
    endtask : convert

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        logic [15:0] r;
        logic [2:0] c;
        logic [14:0] a;
        int n;
        cfg = '0;
        mode = 1'b0;
        r = 16'($urandom(20));
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        compare();
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys_i) mode <= p[0];
            for (int k = 0; k < 150; k++) begin
                // small ranges so limits and bands are hit often
                if (k % 50 == 0) begin
                    @(posedge clk_sys_i);
                    for (int i = 0; i < 8; i++) begin
                        cfg[i] <= '{enable: ($urandom % 4 != 0), upper: 16'h0080 + $urandom % 64,
                            lower: $urandom % 64, hyst: $urandom % 32};
                    end
                    // corner values below must see the new limits
                    @(posedge clk_sys_i);
                end
                c = 3'($urandom % 8);
                case ($urandom % 4)
                    0: r = cfg[c].upper;
                    1: r = cfg[c].lower;
                    default: r = 16'($urandom % 256);
                endcase
                convert(c, r);
            end
            host.xfer({1'b1, 15'h0017}, rd);
            check(rd === 8'h00, "unknown address data");
            compare();
            for (int s = 0; s < 2; s++) begin
                a = s ? `TAS_ADDR_MID_CHANNELS : `TAS_ADDR_LOW_CHANNELS;
                n = inval_seen;
                host.xfer({1'b0, a}, rd);
                check(inval_seen == n + 1, "invalid write pulse");
                compare();
                host.xfer({1'b1, a}, rd);
                check(rd === (s ? exp_q[15:8] : exp_q[7:0]), "read data");
                if (s) exp_q[15:8] = 8'h00;
                else exp_q[7:0] = 8'h00;
                compare();
            end
        end
        // conversion held across a read of channel 0: the set must survive the clear
        @(posedge clk_sys_i) cfg[0] <= '{enable: 1'b1, upper: 16'h0080, lower: 16'h0000,
            hyst: 16'h0000};
        @(posedge clk_sys_i) conv <= '{valid: 1'b1, chan: 3'h0, result: 16'h0100};
        exp_q = predict(exp_q, 3'h0, 16'h0100, cfg[0], mode);
        host.xfer({1'b1, `TAS_ADDR_LOW_CHANNELS}, rd);
        check(rd === exp_q[7:0], "held alert read");
        compare();
        @(posedge clk_sys_i) conv.valid <= 1'b0;
        conclude();
    end
endmodule : tas_alert_status_bench

//--- verif/tas_host_model.sv
// ----------------------------------------
// serial host, mode 0, msb first
// ----------------------------------------
module tas_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // 40 ns half period; sclk stands low between frames
    task automatic half;
        repeat (10) @(posedge clk_i);
    endtask : half

    task automatic xfer(input logic [15:0] instr, output logic [7:0] rdata);
        rdata = 8'h00;
        // pins move only just after a rising edge
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        half();
        for (int i = 0; i < 24; i++) begin
            // data bits toggle: design ignores them
            sdi_o <= (i < 16) ? instr[15 - i] : ~sdi_o;
            half();
            sclk_o <= 1'b1;
            if (i >= 16) rdata[23 - i] = sdo_i;
            half();
            sclk_o <= 1'b0;
        end
        half();
        cs_n_o <= 1'b1;
        sdi_o <= ~sdi_o;
        half();
    endtask : xfer
endmodule : tas_host_model
